// file: hdl/sensor_output_datapath.sv
/*
 * Output data path: skip, scaler, row limiter, output FIFO between
 * timing and output rates, and a serial pixel lane, with APB registers.
 * Assumes a pixel stream from the array core on clk_sys, link clock
 * oversampled as a plain input.
 */
// Local design decisions: the placing of the registers and register access over APB.
// Behaviour
// RULE1 - host keeps coarse exposure at least 4, below frame lines less margin
// RULE2 - host keeps digital gain a multiple of step, inside limits
// RULE3 - host keeps line length above skipped width plus blanking
// RULE4 - host keeps frame length above skipped height plus blanking
// RULE5 - host keeps window starts even, ends odd, ordered, within range
// RULE6 - host keeps end minus start plus odd increment positive
// RULE7 - host keeps even increments even, odd increments odd, within limits
// RULE8 - host keeps output width even, from 256 to 2608
// RULE9 - host keeps output rows even, 2 up to frame length
// RULE10 - output width bit zero forced low in hardware
// RULE11 - host keeps serial row time, with 12 overhead bytes, short enough
// RULE12 - scaler combines pixels, keeps row time, flags fewer valid pixels
// RULE13 - limiter pads each row to programmed output width; rows with no kept pixel get no pad
// RULE14 - host shrinks output size to the scaled image
// RULE15 - output FIFO merges intermittent pixels into contiguous stream
// RULE16 - FIFO written at timing rate, read at output rate
// RULE17 - host matches frame rates and serial row time
// RULE18 - FIFO underrun or overrun raises fatal status flag
// RULE19 - host changes format and dividers only in standby
// RULE20 - serial interface selected after any reset
// RULE21 - serial outputs off when disable bit set or in standby
// RULE22 - clock high idle in data/clock; clock low, data high in strobe
// RULE23 - skip factor from odd increment: 1 to 1, 3 to 2, 7 to 4
// RULE24 - format code picks raw10, raw8 or compressed 8; compressed 8 sends bits 9:2, the same as raw8
`timescale 1ns/1ps
`include "sensor_output_map.svh"
module sensor_output_datapath
    import sensor_output_pkg::*;
#(
    parameter int DEPTH_LOG2 = 4
)
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pix_beat_t core_pix,
    input wire logic link_clk,
    output logic serial_lane0_pos,
    output logic serial_clk_pos,
    output logic serial_enable,
    output logic parallel_enable,
    output logic fatal_error
);
    // ======================================================
    // registers
    logic [31:0] ctrl_r, ctrl_nxt;
    logic [15:0] format_r, format_nxt;
    logic [11:0] width_r, width_nxt;
    logic [2:0] odd_inc_r, odd_inc_nxt;
    logic [7:0] scale_r, scale_nxt;
    logic [1:0] status_r, status_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic overrun, underrun;
    logic [2:0] skip;
    logic access;
    assign access = psel && penable && !pready_r;
    // apb decode; one wait state, answer follows access
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        format_nxt = format_r;
        width_nxt = width_r;
        odd_inc_nxt = odd_inc_r;
        scale_nxt = scale_r;
        prdata_nxt = prdata_r;
        pready_nxt = access;
        pslverr_nxt = 1'b0;
        status_nxt = status_r;
        if (access && pwrite)
        begin
            case (paddr)
                `OFS_CTRL: ctrl_nxt = pwdata;
                `OFS_FORMAT: format_nxt = pwdata[15:0];
                `OFS_OUT_SIZE: width_nxt = {pwdata[11:1], 1'b0}; // RULE10
                `OFS_SKIP: odd_inc_nxt = pwdata[2:0];
                `OFS_SCALE: scale_nxt = pwdata[7:0];
                `OFS_STATUS: status_nxt = status_r & ~pwdata[1:0];
                default: pslverr_nxt = 1'b1;
            endcase
        end
        else if (access)
        begin
            case (paddr)
                `OFS_CTRL: prdata_nxt = ctrl_r;
                `OFS_FORMAT: prdata_nxt = {16'h0000, format_r};
                `OFS_OUT_SIZE: prdata_nxt = {20'h00000, width_r};
                `OFS_SKIP: prdata_nxt = {29'h0, odd_inc_r};
                `OFS_SCALE: prdata_nxt = {24'h000000, scale_r};
                `OFS_STATUS: prdata_nxt = {30'h0, status_r};
                `OFS_ID: prdata_nxt = `ID_VALUE; // arbitrary value
                default:
                begin
                    prdata_nxt = 32'h0;
                    pslverr_nxt = 1'b1;
                end
            endcase
        end
        // set wins over software clear
        if (overrun) status_nxt[`ST_OVERRUN] = 1'b1; // RULE18
        if (underrun) status_nxt[`ST_UNDERRUN] = 1'b1; // RULE18
    end
    // register update; reset picks the serial path
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            ctrl_r <= `CTRL_RESET; // RULE20
            format_r <= `FMT_RAW10;
            width_r <= `WIDTH_RESET;
            odd_inc_r <= 3'h1;
            scale_r <= `SCALE_RESET;
            status_r <= 2'h0;
            prdata_r <= 32'h0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            format_r <= format_nxt;
            width_r <= width_nxt;
            odd_inc_r <= odd_inc_nxt;
            scale_r <= scale_nxt;
            status_r <= status_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    // ======================================================
    // skip factor, a lookup on the odd increment
    always_comb
    begin
        case (odd_inc_r)
            3'h3: skip = 3'h2; // RULE23
            3'h7: skip = 3'h4; // RULE23
            default: skip = 3'h1; // RULE23
        endcase
    end
    // ======================================================
    // skip and scaler: keep one pixel in skip, then scale by 16/m
    logic [2:0] skip_cnt_r, skip_cnt_nxt;
    logic [8:0] acc_r, acc_nxt;
    logic [9:0] sum_r, sum_nxt;
    pix_beat_t scl_r, scl_nxt;
    logic scl_take;
    always_comb
    begin
        skip_cnt_nxt = skip_cnt_r;
        acc_nxt = acc_r;
        sum_nxt = sum_r;
        scl_nxt = core_pix;
        scl_nxt.valid = 1'b0;
        scl_take = 1'b0;
        if (!core_pix.lv)
        begin
            skip_cnt_nxt = 3'h0;
            acc_nxt = 9'h0;
        end
        else if (core_pix.valid)
        begin
            skip_cnt_nxt = (skip_cnt_r + 3'h1 == skip) ? 3'h0
                : skip_cnt_r + 3'h1;
            scl_take = (skip_cnt_r == 3'h0);
        end
        if (scl_take && !ctrl_r[`CTRL_SCALE_EN])
            scl_nxt.valid = 1'b1;
        else if (scl_take)
        begin
            // row time unchanged, only some beats marked valid
            acc_nxt = acc_r + {1'b0, `SCALE_UNITY}; // RULE12
            sum_nxt = core_pix.data;
            if (acc_nxt >= {1'b0, scale_r})
            begin
                acc_nxt = acc_nxt - {1'b0, scale_r};
                scl_nxt.data = 10'((11'(sum_r) + 11'(core_pix.data)) >> 1);
                scl_nxt.valid = 1'b1; // RULE12
            end
        end
    end
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            skip_cnt_r <= 3'h0;
            acc_r <= 9'h0;
            sum_r <= 10'h0;
            scl_r <= '0;
        end
        else
        begin
            skip_cnt_r <= skip_cnt_nxt;
            acc_r <= acc_nxt;
            sum_r <= sum_nxt;
            scl_r <= scl_nxt;
        end
    end
    // ======================================================
    // limiter: pads short rows up to width after line valid falls
    logic [11:0] col_r, col_nxt;
    logic wr_en;
    logic [9:0] wr_data;
    always_comb
    begin
        col_nxt = col_r;
        wr_en = 1'b0;
        wr_data = scl_r.data;
        if (scl_r.valid && col_r < width_r)
        begin
            wr_en = 1'b1;
            col_nxt = col_r + 12'h1;
        end
        else if (!scl_r.lv && col_r != 12'h0 && col_r < width_r)
        begin
            // padding may eat blanking; too wide a width lets the next row fill the rest of this one
            wr_en = 1'b1; // RULE13
            wr_data = 10'h0;
            col_nxt = col_r + 12'h1;
        end
        else if (!scl_r.lv)
            col_nxt = 12'h0;
    end
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            col_r <= 12'h0;
        else
            col_r <= col_nxt;
    end
    // ======================================================
    // output FIFO, written per kept pixel or pad word, read at link rate
    logic [9:0] mem [2**DEPTH_LOG2];
    logic [DEPTH_LOG2:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic full, empty, rd_en, starve;
    assign full = (wp_r - rp_r) == (DEPTH_LOG2+1)'(2**DEPTH_LOG2);
    assign empty = wp_r == rp_r;
    assign overrun = wr_en && full; // RULE18
    // reads only happen when a word waits, so an underrun is the link
    // asking for a word in the middle of a row and finding none
    assign underrun = starve; // RULE18
    always_comb
    begin
        wp_nxt = wp_r + ((wr_en && !full) ? 1'b1 : 1'b0); // RULE16
        rp_nxt = rp_r + ((rd_en && !empty) ? 1'b1 : 1'b0); // RULE15
    end
    always_ff @(posedge clk_sys)
    begin
        if (wr_en && !full)
            mem[wp_r[DEPTH_LOG2-1:0]] <= wr_data;
        if (reset)
        begin
            wp_r <= '0;
            rp_r <= '0;
        end
        else
        begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
        end
    end
    // ======================================================
    // link clock sampled, edges found after two flops
    logic [2:0] lk_r;
    logic lk_fall;
    always_ff @(posedge clk_sys)
        lk_r <= reset ? 3'h0 : {lk_r[1:0], link_clk};
    assign lk_fall = lk_r[2] && !lk_r[1];
    // ======================================================
    // serializer: words in a row go out with one idle link period between them
    ser_state_t st_r, st_nxt;
    logic [9:0] sh_r, sh_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [11:0] oc_r, oc_nxt; // words read so far in the output row
    logic off, strobe;
    logic ser_d, ser_c;
    assign off = ctrl_r[`CTRL_SER_DIS] || ctrl_r[`CTRL_STANDBY];
    assign strobe = ctrl_r[`CTRL_STROBE];
    always_comb
    begin
        st_nxt = st_r;
        sh_nxt = sh_r;
        bit_nxt = bit_r;
        rd_en = 1'b0;
        oc_nxt = oc_r;
        starve = 1'b0;
        case (st_r)
            SER_OFF:
            begin
                oc_nxt = 12'h0;
                if (!off)
                    st_nxt = SER_IDLE;
            end
            SER_IDLE:
                if (off)
                    st_nxt = SER_OFF; // RULE21
                else if (lk_fall && !empty)
                begin
                    rd_en = 1'b1; // RULE15
                    case (format_r)
                        `FMT_RAW8: sh_nxt = {mem[rp_r[DEPTH_LOG2-1:0]][9:2],
                            2'b00}; // RULE24
                        `FMT_COMP: sh_nxt = {mem[rp_r[DEPTH_LOG2-1:0]][9]
                            ? {1'b1, mem[rp_r[DEPTH_LOG2-1:0]][8:2]}
                            : {1'b0, mem[rp_r[DEPTH_LOG2-1:0]][8:2]}, 2'b00};
                        default: sh_nxt = mem[rp_r[DEPTH_LOG2-1:0]]; // RULE24
                    endcase
                    bit_nxt = (format_r == `FMT_RAW10) ? 4'h9 : 4'h7;
                    st_nxt = SER_SHIFT;
                    oc_nxt = (oc_r + 12'h1 == width_r) ? 12'h0
                        : oc_r + 12'h1;
                end
                else if (lk_fall && oc_r != 12'h0)
                begin
                    // starved mid-row: flag it and give up on this row
                    starve = 1'b1; // RULE18
                    oc_nxt = 12'h0;
                end
            SER_SHIFT:
                if (off)
                    st_nxt = SER_OFF; // RULE21
                else if (lk_fall)
                begin
                    sh_nxt = {sh_r[8:0], 1'b0};
                    if (bit_r == 4'h0)
                        st_nxt = SER_IDLE;
                    else
                        bit_nxt = bit_r - 4'h1;
                end
            default: st_nxt = SER_OFF;
        endcase
        // idle levels depend on the signalling mode
        ser_d = (st_r == SER_SHIFT) ? sh_r[9] : strobe; // RULE22
        ser_c = (st_r == SER_SHIFT) ? lk_r[2] : !strobe; // RULE22
        if (off)
        begin
            ser_d = 1'b0; // RULE21
            ser_c = 1'b0;
        end
    end
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            st_r <= SER_IDLE;
            sh_r <= 10'h0;
            bit_r <= 4'h0;
            oc_r <= 12'h0;
            serial_lane0_pos <= 1'b0;
            serial_clk_pos <= 1'b1;
            serial_enable <= 1'b1; // RULE20
            parallel_enable <= 1'b0;
            fatal_error <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            sh_r <= sh_nxt;
            bit_r <= bit_nxt;
            oc_r <= oc_nxt;
            serial_lane0_pos <= ser_d;
            serial_clk_pos <= ser_c;
            serial_enable <= !off; // RULE21
            parallel_enable <= ctrl_r[`CTRL_PAR_EN];
            fatal_error <= |status_r; // RULE18
        end
    end
    // ======================================================
    // checks
    a_width_even: assert property (@(posedge clk_sys) disable iff (reset)
        width_r[0] == 1'b0) else $error("width odd"); // RULE10
    a_err_sticky: assert property (@(posedge clk_sys) disable iff (reset)
        overrun |=> status_r[`ST_OVERRUN]) else $error("overrun lost"); // RULE18
    a_under_sticky: assert property (@(posedge clk_sys) disable iff (reset)
        underrun |=> status_r[`ST_UNDERRUN]) else $error("underrun lost"); // RULE18
    a_serial_off: assert property (@(posedge clk_sys) disable iff (reset)
        off |=> !serial_enable && !serial_lane0_pos) else $error("lane on"); // RULE21
    a_idle_clock: assert property (@(posedge clk_sys) disable iff (reset)
        (st_r == SER_IDLE && !off && !strobe) |=> serial_clk_pos)
        else $error("idle clock low"); // RULE22
    a_skip_map: assert property (@(posedge clk_sys) disable iff (reset)
        odd_inc_r == 3'h7 |-> skip == 3'h4) else $error("skip wrong"); // RULE23
    a_fifo_bound: assert property (@(posedge clk_sys) disable iff (reset)
        (wp_r - rp_r) <= (DEPTH_LOG2+1)'(2**DEPTH_LOG2))
        else $error("fifo count"); // RULE16
    a_pad_limit: assert property (@(posedge clk_sys) disable iff (reset)
        wr_en |-> col_r < width_r) else $error("row overlong"); // RULE13
endmodule

// file: include/sensor_output_map.svh
/*
 * Register offsets, field positions, reset values and codes of the
 * sensor output data path. Assumes an APB slave with 32-bit words.
 */
`ifndef SENSOR_OUTPUT_MAP_SVH
`define SENSOR_OUTPUT_MAP_SVH
// ==========================================================
// register byte offsets
`define OFS_CTRL 12'h000
`define OFS_FORMAT 12'h004
`define OFS_OUT_SIZE 12'h008
`define OFS_SKIP 12'h00c
`define OFS_SCALE 12'h010
`define OFS_STATUS 12'h014
`define OFS_ID 12'h018
// ==========================================================
// control fields
`define CTRL_SER_DIS 12
`define CTRL_PAR_EN 7
`define CTRL_STANDBY 0
`define CTRL_STROBE 1
`define CTRL_SCALE_EN 2
`define CTRL_RESET 32'h0000_0000
// ==========================================================
// data format codes, width and scale reset values, scale unity
`define FMT_RAW10 16'h0a0a
`define FMT_RAW8 16'h0808
`define FMT_COMP 16'h0a08
`define WIDTH_RESET 12'h0a30
`define SCALE_RESET 8'h10
`define SCALE_UNITY 8'h10
// status bits and id value
`define ST_OVERRUN 0
`define ST_UNDERRUN 1
`define ID_VALUE 32'h0000_5a5a
`endif

// file: include/sensor_output_pkg.sv
/*
 * Types of the sensor output data path. Assumes the map header.
 */
package sensor_output_pkg;
    // ======================================================
    // one pixel beat between stages
    typedef struct packed {
        logic lv;
        logic fv;
        logic valid;
        logic [9:0] data;
    } pix_beat_t;
    typedef enum logic [2:0] {
        SER_IDLE = 3'b001,
        SER_SHIFT = 3'b010,
        SER_OFF = 3'b100
    } ser_state_t;
endpackage

// file: tb/host_receiver.sv
/*
 * Host camera receiver model: makes the link clock and collects words
 * from the serial lane, MSB first, one bit per rise of the forwarded
 * clock. Assumes lane data is settled at each such rise.
 */
`timescale 1ns/1ps
module host_receiver
(
    input wire logic run,
    input wire logic [3:0] nbits,
    input wire logic lane,
    input wire logic sclk,
    output logic link_clk
);
    logic [9:0] word_r;
    int cnt;
    logic [9:0] words[$];
    // ==========================================================
    // link clock, 320 ns, stands still outside frames
    initial
    begin
        link_clk = 1'b1;
        #7;
        forever
        begin
            #160;
            if (run)
                link_clk = ~link_clk;
        end
    end
    // ==========================================================
    // gated by run so idle-level returns add no stray bits
    always @(posedge sclk or negedge run)
    begin
        if (!run)
            cnt = 0;
        else
        begin
            word_r = {word_r[8:0], lane};
            cnt++;
            if (cnt == int'(nbits))
            begin
                words.push_back(nbits == 4'd10 ? word_r : {2'b00, word_r[7:0]});
                cnt = 0;
            end
        end
    end
endmodule

// file: tb/tb.sv
/*
 * Self-checking bench of the output data path: APB master, pixel
 * source, queue model of the serial words. Assumes host_receiver.
 */
`timescale 1ns/1ps
`include "sensor_output_map.svh"
module tb
    import sensor_output_pkg::*;
;
    logic clk_sys, reset, psel, penable, pwrite, err, run;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, link_clk, serial_lane0_pos, serial_clk_pos;
    logic serial_enable, parallel_enable, fatal_error;
    logic [3:0] nbits;
    pix_beat_t core_pix;
    int bad_count, checks_done;
    integer seed = 32'hae46;
    logic [9:0] exp_q[$];
    logic [15:0] fmts[3] = '{`FMT_RAW10, `FMT_RAW8, `FMT_COMP};
    sensor_output_datapath i_sensor_output_datapath (.clk_sys(clk_sys),
        .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .core_pix(core_pix), .link_clk(link_clk),
        .serial_lane0_pos(serial_lane0_pos), .serial_clk_pos(serial_clk_pos),
        .serial_enable(serial_enable), .parallel_enable(parallel_enable),
        .fatal_error(fatal_error));
    host_receiver i_host_receiver (.run(run), .nbits(nbits),
        .lane(serial_lane0_pos), .sclk(serial_clk_pos), .link_clk(link_clk));
    // ==========================================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want)
        begin
            bad_count++;
            $display("ERROR %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // hold the request until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            bad_count++;
            $display("ERROR %0t: no pready", $time);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // one row; gap idle beats between valid pixels, pad zeros expected;
    // skp keeps every skp-th pixel, half averages kept pairs
    task automatic send_row(input int n, input int gap, input int pad,
        input int skp, input bit half);
        logic [9:0] v, p, w;
        int k, j;
        bit keep;
        core_pix <= '{1'b0, 1'b1, 1'b0, 10'h000};
        repeat (4) @(posedge clk_sys);
        for (int i = 0; i < n * (gap + 1); i++)
        begin
            v = 10'($random(seed));
            k = i % (gap + 1);
            j = i / (gap + 1);
            keep = k == 0 && j % skp == 0;
            core_pix <= '{1'b1, 1'b1, k == 0, v};
            w = half ? 10'((11'(p) + 11'(v)) >> 1) : v;
            if (keep && (!half || (j / skp) % 2 == 1))
                exp_q.push_back(nbits == 4'd10 ? w : {2'b00, w[9:2]});
            if (keep)
                p = v;
            @(posedge clk_sys);
        end
        core_pix <= '{1'b0, 1'b1, 1'b0, 10'h000};
        repeat (pad) exp_q.push_back(10'h000);
        repeat (8) @(posedge clk_sys);
        core_pix <= '0;
    endtask
    // compare every word the receiver collected with the model
    task automatic drain;
        int n;
        n = 0;
        while (i_host_receiver.words.size() < exp_q.size() && n < 20000)
        begin
            @(posedge clk_sys);
            n++;
        end
        check(32'(i_host_receiver.words.size()), 32'(exp_q.size()));
        foreach (exp_q[i])
            check(32'(i_host_receiver.words[i]), 32'(exp_q[i]));
        exp_q.delete();
        i_host_receiver.words.delete();
        run <= 1'b0;
    endtask
    // ==========================================================
    // clock, watchdog and main sequence
    initial
    begin
        clk_sys = 1'b0;
        forever
            #20 clk_sys = ~clk_sys;
    end
    initial
    begin
        #(80000 * 40);
        bad_count++;
        test_done;
    end
    initial
    begin
        {reset, psel, penable, pwrite, run} = 5'b10000;
        paddr = 12'h000;
        pwdata = 32'h0;
        core_pix = '0;
        nbits = 4'd8;
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        check(32'({serial_enable, serial_clk_pos}), 32'h3);
        check(32'({parallel_enable, fatal_error}), 32'h0);
        apb(1'b0, `OFS_ID, 32'h0);
        check(rd, `ID_VALUE);
        apb(1'b0, `OFS_OUT_SIZE, 32'h0);
        check(rd, 32'(`WIDTH_RESET));
        apb(1'b0, 12'h020, 32'h0);
        check({rd[30:0], err}, 32'h1);
        apb(1'b1, `OFS_OUT_SIZE, 32'h105);
        apb(1'b0, `OFS_OUT_SIZE, 32'h0);
        check(rd, 32'h104);
        $display("registers test done");
        apb(1'b1, `OFS_CTRL, 32'h1080);
        repeat (6) @(posedge clk_sys);
        check(32'({serial_enable, serial_clk_pos, serial_lane0_pos}), 0);
        check(32'(parallel_enable), 32'h1);
        apb(1'b1, `OFS_CTRL, 32'h2);
        repeat (6) @(posedge clk_sys);
        check(32'({serial_enable, serial_clk_pos, serial_lane0_pos}), 5);
        $display("idle levels test done");
        foreach (fmts[f])
        begin
            apb(1'b1, `OFS_CTRL, 32'h1);
            repeat (6) @(posedge clk_sys);
            check(32'(serial_enable), 32'h0);
            apb(1'b1, `OFS_FORMAT, 32'(fmts[f]));
            apb(1'b1, `OFS_OUT_SIZE, f == 0 ? 32'h6 : 32'h4);
            apb(1'b1, `OFS_CTRL, 32'h0);
            nbits <= fmts[f] == `FMT_RAW10 ? 4'd10 : 4'd8;
            // arm the receiver only after the idle clock has risen
            @(posedge clk_sys);
            run <= 1'b1;
            send_row(4, f, f == 0 ? 2 : 0, 1, 1'b0);
            drain;
        end
        $display("format stream test done");
        for (int s = 2; s <= 4; s += 2)
        begin
            apb(1'b1, `OFS_SKIP, 32'(2 * s - 1));
            apb(1'b1, `OFS_OUT_SIZE, 32'(8 / s));
            run <= 1'b1;
            send_row(8, 0, 0, s, 1'b0);
            drain;
        end
        $display("skip test done");
        apb(1'b1, `OFS_CTRL, 32'h1);
        apb(1'b1, `OFS_SCALE, 32'h20);
        apb(1'b1, `OFS_SKIP, 32'h1);
        apb(1'b1, `OFS_OUT_SIZE, 32'h4);
        apb(1'b1, `OFS_CTRL, 32'h4);
        @(posedge clk_sys);
        run <= 1'b1;
        send_row(8, 0, 0, 1, 1'b1);
        drain;
        apb(1'b1, `OFS_CTRL, 32'h0);
        $display("scaler test done");
        apb(1'b1, `OFS_OUT_SIZE, 32'd40);
        run <= 1'b1;
        send_row(40, 0, 0, 1, 1'b0);
        check(32'(fatal_error), 32'h1);
        apb(1'b0, `OFS_STATUS, 32'h0);
        check(rd & 32'h1, 32'h1);
        repeat (2000) @(posedge clk_sys);
        // the cut row leaves the link starved once the fifo runs dry
        apb(1'b0, `OFS_STATUS, 32'h0);
        check(rd & 32'h3, 32'h3);
        run <= 1'b0;
        apb(1'b1, `OFS_STATUS, 32'h3);
        apb(1'b0, `OFS_STATUS, 32'h0);
        check(32'({rd[1:0], fatal_error}), 32'h0);
        $display("overrun test done");
        test_done;
    end
endmodule
